// ---- design/pps_top.sv ----
/*
 power-up reset, preload, 64-bit signature, security fuse and eight
 macrocells, reached over ahb-lite. assumes hresetn comes from the
 supply detector and that board pins are asynchronous to hclk.
*/
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pps_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic array_clk,
    input wire logic oe_pin_n,
    input wire logic [7:0] io_in,
    input wire logic [7:0] io_driven,
    output logic [7:0] io_out,
    output logic [7:0] io_oe
);
    logic [1:0] pwr_sync_q;
    logic [7:0] pr_cnt_q;
    logic ready_q;
    logic [2:0] clk_sync_q;
    logic clk_en;
    logic [1:0] oe_sync_q;
    logic [7:0] in_s1_q, in_s2_q, drv_s1_q, drv_s2_q;
    logic [7:0] pin_level;
    logic [1:0] mode_q;
    logic secure_q;
    logic refused_q;
    logic [15:0] mccfg_q;
    logic [31:0] sig_lo_q, sig_hi_q;
    logic [31:0] fuse_q;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic preload_en;
    logic [7:0] preload_val;
    logic [7:0] reg_bits;
    logic [7:0] pin_d, pin_oe_d;
    logic [7:0] sum_term, oe_term;
    logic [31:0] rdata_d;
    logic rd_sec;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // power-up interval: macrocell registers stay clear and clocks are ignored meanwhile
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pr_cnt_q <= 8'h00;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            pr_cnt_q <= pr_cnt_q + 8'h01;
            ready_q <= (pr_cnt_q == pps_pkg::PR_CYCLES_8 - 8'h01);
        end
    end

    // pin synchronisers; the edge detector only looks at stage two and three
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sync_q <= 3'h0;
            oe_sync_q <= 2'h3;
            in_s1_q <= 8'h00;
            in_s2_q <= 8'h00;
            drv_s1_q <= 8'h00;
            drv_s2_q <= 8'h00;
            pwr_sync_q <= 2'h0;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], array_clk};
            oe_sync_q <= {oe_sync_q[0], oe_pin_n};
            in_s1_q <= io_in;
            in_s2_q <= in_s1_q;
            drv_s1_q <= io_driven;
            drv_s2_q <= drv_s1_q;
            pwr_sync_q <= {pwr_sync_q[0], ready_q};
        end
    end

    // edges are taken only after the interval; setup is the board's job
    assign clk_en = clk_sync_q[1] & ~clk_sync_q[2] & ready_q;
    assign pin_level = (in_s2_q & drv_s2_q) | ~drv_s2_q;

    // stand-in array: each sum term mixes its own pin with its neighbour
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            sum_term[i] = pin_level[i] ^ reg_bits[(i + 1) % 8];
            oe_term[i] = pin_level[(i + 7) % 8];
        end
    end

    // ahb-lite slave: zero wait state, write completes the cycle after address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else if (hready) begin
            wr_pend_q <= hsel & htrans[1] & hwrite;
            wr_addr_q <= haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= 2'(pps_pkg::PPS_MODE_REGISTERED);
            mccfg_q <= pps_pkg::MCCFG_RESET;
        end else if (wr_pend_q && hit(wr_addr_q, pps_pkg::OFF_CTRL) && !secure_q) begin
            // unknown code 3 falls back to registered mode
            mode_q <= (hwdata[1:0] == 2'h3) ? 2'(pps_pkg::PPS_MODE_REGISTERED)
                : hwdata[1:0];
        end else if (wr_pend_q && hit(wr_addr_q, pps_pkg::OFF_MCCFG) && !secure_q) begin
            mccfg_q <= hwdata[15:0];
        end
    end

    // one-way fuse: no path clears it short of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            secure_q <= 1'b0;
        end else if (wr_pend_q && hit(wr_addr_q, pps_pkg::OFF_CTRL)
            && hwdata[pps_pkg::CTRL_SECURE_BIT]) begin
            secure_q <= 1'b1;
        end
    end

    // fuse pattern store; writes are locked once secured
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_q <= 32'h0000_0000;
        end else if (wr_pend_q && hit(wr_addr_q, pps_pkg::OFF_FUSE) && !secure_q) begin
            fuse_q <= hwdata;
        end
    end

    // signature stays writable and readable regardless of security
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sig_lo_q <= pps_pkg::SIG_RESET;
            sig_hi_q <= pps_pkg::SIG_RESET;
        end else if (wr_pend_q && hit(wr_addr_q, pps_pkg::OFF_SIG_LO)) begin
            sig_lo_q <= hwdata;
        end else if (wr_pend_q && hit(wr_addr_q, pps_pkg::OFF_SIG_HI)) begin
            sig_hi_q <= hwdata;
        end
    end

    assign preload_en = wr_pend_q && hit(wr_addr_q, pps_pkg::OFF_PRELOAD)
        && !secure_q && ready_q;
    assign preload_val = hwdata[7:0];

    // refused flag: sticky, cleared by reading status; a new refusal wins
    assign rd_sec = hsel & htrans[1] & ~hwrite & hready & secure_q
        & hit(haddr[11:0], pps_pkg::OFF_FUSE);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refused_q <= 1'b0;
        end else if (rd_sec || (wr_pend_q && secure_q
            && hit(wr_addr_q, pps_pkg::OFF_PRELOAD))) begin
            refused_q <= 1'b1;
        end else if (hsel && htrans[1] && !hwrite && hready
            && hit(haddr[11:0], pps_pkg::OFF_STATUS)) begin
            refused_q <= 1'b0;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (haddr[11:0])
            pps_pkg::OFF_CTRL: rdata_d = {29'h0, secure_q, mode_q};
            pps_pkg::OFF_STATUS: rdata_d = {29'h0, refused_q, secure_q, pwr_sync_q[1]};
            pps_pkg::OFF_MCCFG: rdata_d = {16'h0000, mccfg_q};
            pps_pkg::OFF_SIG_LO: rdata_d = sig_lo_q;
            pps_pkg::OFF_SIG_HI: rdata_d = sig_hi_q;
            pps_pkg::OFF_FUSE: rdata_d = secure_q ? pps_pkg::FUSE_REFUSED : fuse_q;
            pps_pkg::OFF_REGS: rdata_d = {24'h000000, reg_bits};
            pps_pkg::OFF_PINS: rdata_d = {24'h000000, pin_level};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                hrdata <= rdata_d;
            end
        end
    end

    for (genvar g = 0; g < 8; g++) begin : g_mc
        pps_macrocell u_mc (
            .hclk(hclk),
            .hresetn(hresetn),
            .clk_en(clk_en),
            .cfg(mccfg_q[2*g +: 2]),
            .mode(mode_q),
            .sum_term(sum_term[g]),
            .oe_term(oe_term[g]),
            .oe_pin_n(oe_sync_q[1]),
            .preload_en(preload_en),
            .preload_val(preload_val[g]),
            .reg_q(reg_bits[g]),
            .pin_d(pin_d[g]),
            .pin_oe_d(pin_oe_d[g])
        );
    end

    // pins registered; reset shows high level on registered outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_out <= 8'hFF;
            io_oe <= 8'h00;
        end else begin
            io_out <= pin_d;
            io_oe <= pin_oe_d;
        end
    end
endmodule // pps_top
`default_nettype wire

// ---- design/pps_pkg.sv ----
/*
 package for the power-up, preload, signature and security block:
 register offsets, reset values, mode codes and timing constants.
 assumes nothing of its surroundings.
*/
package pps_pkg;
    localparam int unsigned CLK_MHZ = 100;
    // power-up reset interval, nanoseconds, typical and longest
    localparam int unsigned PR_TYP_NS = 600;
    localparam int unsigned PR_MAX_NS = 1000;
    localparam int unsigned PR_CYCLES = (PR_TYP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] PR_CYCLES_8 = 8'(PR_CYCLES);

    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_MCCFG = 12'h008;
    localparam logic [11:0] OFF_PRELOAD = 12'h00C;
    localparam logic [11:0] OFF_SIG_LO = 12'h010;
    localparam logic [11:0] OFF_SIG_HI = 12'h014;
    localparam logic [11:0] OFF_FUSE = 12'h018;
    localparam logic [11:0] OFF_REGS = 12'h01C;
    localparam logic [11:0] OFF_PINS = 12'h020;

    // ctrl fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_SECURE_BIT = 2;
    // status fields
    localparam int unsigned ST_READY_BIT = 0;
    localparam int unsigned ST_SECURE_BIT = 1;
    localparam int unsigned ST_REFUSED_BIT = 2;

    localparam logic [31:0] FUSE_REFUSED = 32'h0000_0000;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] MCCFG_RESET = 16'h0000;
    localparam logic [31:0] SIG_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        PPS_MODE_SIMPLE,
        PPS_MODE_COMPLEX,
        PPS_MODE_REGISTERED
    } pps_mode_t;

    typedef enum logic [1:0] {
        PPS_MC_REG_OUT,
        PPS_MC_COMB_IO,
        PPS_MC_COMB_OUT,
        PPS_MC_INPUT
    } pps_mc_t;
endpackage

// ---- design/pps_macrocell.sv ----
/*
 one macrocell: register with preload, output mux and enable.
 assumes sum term, enable term and pin level come from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_macrocell (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic [1:0] cfg,
    input wire logic [1:0] mode,
    input wire logic sum_term,
    input wire logic oe_term,
    input wire logic oe_pin_n,
    input wire logic preload_en,
    input wire logic preload_val,
    output var logic reg_q,
    output var logic pin_d,
    output var logic pin_oe_d
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_q <= 1'b0;
        end else if (preload_en) begin
            reg_q <= preload_val;
        end else if (clk_en && cfg == 2'(pps_pkg::PPS_MC_REG_OUT)) begin
            reg_q <= sum_term;
        end
    end

    always_comb begin
        pin_d = sum_term;
        pin_oe_d = 1'b0;
        case (cfg)
            2'(pps_pkg::PPS_MC_REG_OUT): begin
                pin_d = ~reg_q;
                pin_oe_d = !oe_pin_n;
            end
            2'(pps_pkg::PPS_MC_COMB_IO): begin
                // simple mode has no enable term: always driven
                pin_oe_d = (mode == 2'(pps_pkg::PPS_MODE_SIMPLE)) ? 1'b1 : oe_term;
            end
            2'(pps_pkg::PPS_MC_COMB_OUT): pin_oe_d = 1'b1;
            default: pin_oe_d = 1'b0;
        endcase
    end
endmodule // pps_macrocell
`default_nettype wire

// ---- test/pps_props.sv ----
/*
 assertion checker on the pps_top ports.
 assumes it is bound into every pps_top instance.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe
);
    logic rd_q, wr_q, sec_q, rd_st, rd_ct, rd_fu;
    logic [11:0] ad_q;
    logic [1:0] mc_q;
    logic [6:0] cnt_q;
    assign rd_st = rd_q && ad_q == pps_pkg::OFF_STATUS;
    assign rd_ct = rd_q && ad_q == pps_pkg::OFF_CTRL;
    assign rd_fu = rd_q && ad_q == pps_pkg::OFF_FUSE;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_q, wr_q, sec_q, ad_q, mc_q, cnt_q} <= '0;
        end else begin
            rd_q <= hsel && htrans[1] && hready && !hwrite;
            wr_q <= hsel && htrans[1] && hready && hwrite;
            ad_q <= haddr[11:0];
            cnt_q <= cnt_q + 7'(cnt_q < 7'd100);
            // one-way, so only reset clears this copy
            if (wr_q && ad_q == pps_pkg::OFF_CTRL && hwdata[2]) sec_q <= 1'b1;
            if (wr_q && ad_q == pps_pkg::OFF_MCCFG && !sec_q) mc_q <= hwdata[1:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_release_high: assert property ($rose(hresetn) |-> io_out == 8'hFF)
        else $error("pins not high after reset");
    a_quiet_interval: assert property (
        cnt_q < 7'(pps_pkg::PR_CYCLES) |-> io_out == 8'hFF)
        else $error("register moved inside reset interval");
    a_power_ready: assert property (rd_st && cnt_q == 7'd100 |-> hrdata[0])
        else $error("power-up done flag missing");
    a_fuse_refused: assert property (
        rd_fu && sec_q && $past(sec_q) |-> hrdata == pps_pkg::FUSE_REFUSED)
        else $error("fuse pattern readable when secured");
    a_status_secure: assert property (rd_st && sec_q == $past(sec_q) |-> hrdata[1] == sec_q)
        else $error("secure status wrong");
    a_ctrl_secure: assert property (rd_ct && sec_q == $past(sec_q) |-> hrdata[2] == sec_q)
        else $error("secure readback wrong");
    a_mode_legal: assert property (rd_ct |-> hrdata[1:0] != 2'b11)
        else $error("fourth mode reported");
    a_input_undriven: assert property (mc_q == 2'b11 && $past(mc_q, 2) == 2'b11 |-> !io_oe[0])
        else $error("input cell drives its pin");
endmodule // pps_props
bind pps_top pps_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

// ---- test/pps_board.sv ----
/*
 board model: drives the array clock pin.
 assumes run stays low through the power-up reset interval.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_board (
    input wire logic hclk,
    input wire logic run,
    output logic array_clk
);
    logic [2:0] div_q;
    // pin stands still until setup is met, slow so inputs settle first
    always_ff @(posedge hclk) begin
        div_q <= run ? div_q + 3'd1 : 3'd0;
        array_clk <= run && div_q[2];
    end
endmodule // pps_board
`default_nettype wire

// ---- test/test_pld_powerup_security_config.sv ----
/*
 testbench of pps_top: ahb-lite master, board model, queue checking.
 assumes pps_props is bound and pps_board drives the clock pin.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pld_powerup_security_config;
    logic hclk, hresetn, hsel, hwrite, run, oe_pin_n, hreadyout, hresp, rdp, array_clk;
    logic [31:0] haddr, hwdata, hrdata, sig;
    logic [1:0] htrans;
    logic [7:0] io_in, io_driven, io_out, io_oe, v;
    logic [31:0] exp_q[$];
    int error_cnt, n_compared, seed, cyc, i;
    pps_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .array_clk(array_clk), .oe_pin_n(oe_pin_n), .io_in(io_in),
        .io_driven(io_driven), .io_out(io_out), .io_oe(io_oe));
    pps_board board_u (.hclk(hclk), .run(run), .array_clk(array_clk));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, 20'h0, a, 2'b10, w};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // read data stands during the data phase, so take it at that edge
    always @(posedge hclk) begin
        if (rdp) cmp(hrdata, exp_q.pop_front());
        rdp <= hsel && htrans[1] && !hwrite && hreadyout;
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        seed = 36181;
        {hsel, haddr, htrans, hwrite, hwdata, io_in, io_driven} = '0;
        {hresetn, run, oe_pin_n, rdp, cyc, error_cnt, n_compared} = '0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(pps_pkg::OFF_REGS, {24'h0, pps_pkg::REG_RESET});
        rd(pps_pkg::OFF_PINS, 32'hFF);
        repeat (70) @(posedge hclk);
        rd(pps_pkg::OFF_STATUS, 32'h1);
        cmp({31'h0, hresp}, 32'h0);
        $display("power-up test done");
        for (i = 0; i < 2; i++) begin
            v = i ? ~v : 8'($random(seed));
            bus(1'b1, pps_pkg::OFF_PRELOAD, {24'h0, v});
            rd(pps_pkg::OFF_REGS, {24'h0, v});
            repeat (4) @(posedge hclk);
            cmp({24'h0, io_out}, {24'h0, ~v});
        end
        sig = $random(seed);
        bus(1'b1, pps_pkg::OFF_SIG_LO, sig);
        bus(1'b1, pps_pkg::OFF_SIG_HI, ~sig);
        rd(pps_pkg::OFF_SIG_LO, sig);
        rd(pps_pkg::OFF_SIG_HI, ~sig);
        for (i = 0; i < 4; i++) begin
            bus(1'b1, pps_pkg::OFF_CTRL, 32'(i));
            rd(pps_pkg::OFF_CTRL, (i == 3) ? 32'h2 : 32'(i));
        end
        bus(1'b1, pps_pkg::OFF_MCCFG, 32'hFFFF);
        rd(pps_pkg::OFF_MCCFG, 32'hFFFF);
        repeat (6) @(posedge hclk);
        cmp({24'h0, io_oe}, 32'h0);
        // simple mode has no enable term, so comb io cells always drive
        bus(1'b1, pps_pkg::OFF_CTRL, 32'h0);
        bus(1'b1, pps_pkg::OFF_MCCFG, 32'h5555);
        repeat (6) @(posedge hclk);
        cmp({24'h0, io_oe}, 32'hFF);
        bus(1'b1, pps_pkg::OFF_CTRL, 32'h2);
        bus(1'b1, pps_pkg::OFF_MCCFG, 32'h0);
        $display("preload, signature and mode tests done");
        // board drives random levels while the array clock runs
        {io_in, io_driven, oe_pin_n} <= 17'($random(seed));
        run <= 1'b1;
        repeat (200) @(posedge hclk);
        run <= 1'b0;
        repeat (10) @(posedge hclk);
        bus(1'b1, pps_pkg::OFF_PRELOAD, {24'h0, v});
        bus(1'b1, pps_pkg::OFF_CTRL, 32'h6);
        rd(pps_pkg::OFF_STATUS, 32'h3);
        rd(pps_pkg::OFF_FUSE, pps_pkg::FUSE_REFUSED);
        rd(pps_pkg::OFF_STATUS, 32'h7);
        bus(1'b1, pps_pkg::OFF_PRELOAD, {24'h0, ~v});
        rd(pps_pkg::OFF_REGS, {24'h0, v});
        rd(pps_pkg::OFF_STATUS, 32'h7);
        rd(pps_pkg::OFF_STATUS, 32'h3);
        rd(pps_pkg::OFF_SIG_HI, ~sig);
        cmp({31'h0, hresp}, 32'h0);
        $display("security test done");
        final_report();
    end
endmodule // test_pld_powerup_security_config
`default_nettype wire
